// ==== pkg/wwdt_cnt_if.sv ====
// Link between the watchdog control logic and its counter chain.
// Assumes both ends sit in the same clock domain.
interface wwdt_cnt_if;
  logic                 tick;         // One oscillator period elapsed.
  logic                 clear;        // Restart the whole chain.
  logic                 run;          // Counting allowed.
  logic [4:0]           shift;        // Log2 of the full period in ticks.
  wwdt_pkg::wwdt_count_t count;       // Present chain value.
  logic                 expire;       // One-cycle time-out pulse.
  logic                 window_open;  // In the last quarter of the period.

  modport ctrl (
    output tick,
    output clear,
    output run,
    output shift,
    input  count,
    input  expire,
    input  window_open
  );

  modport core (
    input  tick,
    input  clear,
    input  run,
    input  shift,
    output count,
    output expire,
    output window_open
  );
endinterface

// ==== pkg/wwdt_params.svh ====
// Offsets, field positions, reset values and timing counts of the
// windowed watchdog. Assumes inclusion by bare name from design files.
`ifndef WWDT_PARAMS_SVH
`define WWDT_PARAMS_SVH

// Register byte offsets on the APB slave.
`define WWDT_ADDR_RESET_CTRL  12'h000
`define WWDT_ADDR_CONFIG      12'h004
`define WWDT_ADDR_STATUS      12'h008

// Reset control register fields.
`define WWDT_RC_SOFT_EN       5
`define WWDT_RC_TIMEOUT       4
`define WWDT_RC_SLEEP         3
`define WWDT_RC_IDLE          2

// Configuration word fields.
`define WWDT_CFG_PS_LO        0
`define WWDT_CFG_PS_HI        3
`define WWDT_CFG_PRESCALE     4
`define WWDT_CFG_WIN_DIS      6
`define WWDT_CFG_EN_LO        7
`define WWDT_CFG_EN_HI        8
`define WWDT_CFG_RESET        32'h0000_01df

// Status register fields.
`define WWDT_ST_WINDOW        24
`define WWDT_ST_RUNNING       25
`define WWDT_ST_SLEEP         26
`define WWDT_ST_IDLE          27

// Prescaler widths in bits (divide by 32 or by 128).
`define WWDT_PRE_SHORT        5'h05
`define WWDT_PRE_LONG         5'h07

// Timing: system clock and nominal oscillator frequency in hertz.
`define WWDT_CLK_FREQ_HZ      100000000
`define WWDT_OSC_FREQ_HZ      31000
`define WWDT_OSC_DIV \
  ((`WWDT_CLK_FREQ_HZ + `WWDT_OSC_FREQ_HZ / 2) / `WWDT_OSC_FREQ_HZ)

`endif

// ==== pkg/wwdt_pkg.sv ====
// Types shared by the windowed watchdog modules.
// Assumes nothing beyond a SystemVerilog compiler.
package wwdt_pkg;

  // Power state of the device as the watchdog tracks it.
  typedef enum logic [1:0] {
    WWDT_RUN,
    WWDT_SLEEP,
    WWDT_IDLE
  } wwdt_mode_e;

  // Oscillator tick count of prescaler and postscaler together.
  typedef logic [21:0] wwdt_count_t;

endpackage

// ==== sim/tb.sv ====
// Self-checking bench for the windowed watchdog top level.
// Assumes the checker file binds itself into the design.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TCK = 3226;  // Clocks per oscillator tick.
  logic        clk;           // System clock.
  logic        nrst;          // Reset, active low.
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wd_rst;
  logic        wake;
  logic        osc_on;
  logic [4:0]  evs;           // Clear, sleep, idle, wake, switch.
  logic [31:0] q;             // Last read word.
  logic        e;             // Last error answer.
  logic        r;
  logic        w;
  int          n;
  int          n_errors;
  int          check_count;

  wwdt_top dut_u (.i_clock(clk), .i_nrst(nrst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_watchdog_clear_instr(evs[0]),
    .i_power_save_sleep(evs[1]), .i_power_save_idle(evs[2]),
    .i_wake_other(evs[3]), .i_clock_switch_done(evs[4]),
    .o_watchdog_reset(wd_rst), .o_wake(wake),
    .o_low_power_rc_osc_on(osc_on));

  // Clock at 100 MHz.
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Prints the verdict and ends the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; waits on ready with a bound, then releases.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  // Reads a word and compares the masked bits.
  task automatic rchk(input string nm, input logic [11:0] a,
                      input logic [31:0] m, exp);
    apb(1'h0, a, 32'h0000_0000);
    chk(nm, q & m, exp);
  endtask

  // Pulses one event and notes any request in the next three cycles.
  task automatic ev(input int i);
    r = 1'h0;
    w = 1'h0;
    evs[i] <= 1'h1;
    @(posedge clk);
    evs[i] <= 1'h0;
    repeat (3) begin
      @(posedge clk);
      r = r | wd_rst;
      w = w | wake;
    end
  endtask

  // Holds reset for 20 cycles; the first wait avoids a same-step drive.
  task automatic do_reset();
    @(posedge clk);
    nrst <= 1'h0;
    repeat (20) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
  endtask

  task automatic t_regs();
    rchk("cfg", 12'h004, 32'hffff_ffff, 32'h0000_01df);
    rchk("rc", 12'h000, 32'h0000_003c, 32'h0000_0000);
    rchk("run", 12'h008, 32'h0200_0000, 32'h0200_0000);
    chk("osc", {31'h0, osc_on}, 32'h0000_0001);
    apb(1'h1, 12'h00c, 32'hffff_ffff);
    rchk("unmap", 12'h00c, 32'hffff_ffff, 32'h0000_0000);
    chk("err", {31'h0, e}, 32'h0000_0001);
    $display("test regs done");
  endtask

  // Field 00 with the window armed: a clear must do nothing.
  task automatic t_off();
    apb(1'h1, 12'h004, 32'h0000_0000);
    rchk("off", 12'h008, 32'h023f_ffff, 32'h0000_0000);
    ev(0);
    chk("offclr", {30'h0, r, w}, 32'h0000_0000);
    chk("oscoff", {31'h0, osc_on}, 32'h0000_0000);
    $display("test off done");
  endtask

  task automatic t_soft();
    apb(1'h1, 12'h004, 32'h0000_0080);
    apb(1'h1, 12'h000, 32'h0000_0020);
    rchk("swign", 12'h000, 32'h0000_0020, 32'h0000_0000);
    ev(2);
    rchk("idle", 12'h008, 32'h0a00_0000, 32'h0a00_0000);
    ev(3);
    ev(1);
    rchk("sleep", 12'h008, 32'h0600_0000, 32'h0400_0000);
    ev(3);
    rchk("flags", 12'h000, 32'h0000_000c, 32'h0000_000c);
    apb(1'h1, 12'h000, 32'h0000_0000);
    rchk("flclr", 12'h000, 32'h0000_000c, 32'h0000_0000);
    apb(1'h1, 12'h004, 32'h0000_0100);
    rchk("swoff", 12'h008, 32'h0200_0000, 32'h0000_0000);
    apb(1'h1, 12'h000, 32'h0000_0020);
    rchk("swon", 12'h008, 32'h0200_0000, 32'h0200_0000);
    do_reset();
    rchk("swrst", 12'h000, 32'h0000_0020, 32'h0000_0000);
    $display("test soft done");
  endtask

  // Windowed, shortest period: a clear at once is too early.
  task automatic t_early();
    apb(1'h1, 12'h004, 32'h0000_0180);
    ev(0);
    chk("early", {30'h0, r, w}, 32'h0000_0002);
    rchk("toflag", 12'h000, 32'h0000_0010, 32'h0000_0010);
    rchk("cnt", 12'h008, 32'h003f_fffe, 32'h0000_0000);
    apb(1'h1, 12'h000, 32'h0000_0010);
    rchk("kept", 12'h000, 32'h0000_0010, 32'h0000_0010);
    apb(1'h1, 12'h000, 32'h0000_0000);
    rchk("toclr", 12'h000, 32'h0000_0010, 32'h0000_0000);
    apb(1'h1, 12'h004, 32'h0000_01c0);
    ev(0);
    chk("nowin", {30'h0, r, w}, 32'h0000_0000);
    $display("test early done");
  endtask

  // Always-on watchdog times out in Sleep and wakes without reset.
  task automatic t_sleep();
    ev(4);
    rchk("switch", 12'h008, 32'h003f_fffe, 32'h0000_0000);
    ev(1);
    n = 0;
    while (!(r | w) && n < 34 * TCK) begin
      @(posedge clk);
      n++;
      r = wd_rst;
      w = wake;
    end
    chk("swake", {30'h0, r, w}, 32'h0000_0001);
    chk("period", {31'h0, n >= 31 * TCK && n <= 32 * TCK + 8},
        32'h0000_0001);
    rchk("flags2", 12'h000, 32'h0000_0018, 32'h0000_0018);
    $display("test sleep done");
  endtask

  // Cuts a hang short; the tests need about 103400 cycles.
  initial begin
    repeat (125000) @(posedge clk);
    n_errors++;
    $display("BAD run expected end seen hang");
    close_out();
  end

  initial begin
    nrst = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    evs = 5'h00;
    n_errors = 0;
    check_count = 0;
    do_reset();
    t_regs();
    t_off();
    t_soft();
    t_early();
    t_sleep();
    close_out();
  end
endmodule

// ==== sim/wwdt_chk.sv ====
// Port checks for the windowed watchdog, bound into its top module.
// Assumes one clock domain with a synchronous active-low reset.
module wwdt_chk (
  input wire logic        i_clock,
  input wire logic        i_nrst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic [11:0] i_paddr,
  input wire logic        i_watchdog_clear_instr,
  input wire logic        i_clock_switch_done,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_watchdog_reset,
  input wire logic        o_wake,
  input wire logic        o_low_power_rc_osc_on
);
  // All checks sleep while reset is applied.
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);

  // Reset and wake requests are single pulses and never coincide.
  a_reset_pulse: assert property (
      o_watchdog_reset |=> !o_watchdog_reset)
    else $error("reset request held too long");
  a_wake_pulse: assert property (o_wake |=> !o_wake)
    else $error("wake request held too long");
  a_wake_no_reset: assert property (
      !(o_wake && o_watchdog_reset))
    else $error("wake and reset requested together");
  // A request can only come from a running, hence clocked, watchdog.
  a_osc_running: assert property (
      (o_wake || o_watchdog_reset) |-> o_low_power_rc_osc_on)
    else $error("time-out without oscillator request");
  // A restart leaves a full period, so no wake may follow soon after.
  // Three cycles of slack cover an expiry already in flight.
  a_clear_restart: assert property (
      i_watchdog_clear_instr |-> ##3 !o_wake [*8])
    else $error("wake shortly after clear");
  a_switch_restart: assert property (
      i_clock_switch_done |-> ##3 !o_wake [*8])
    else $error("wake shortly after clock switch");
  // The slave always inserts exactly one wait state.
  a_ready_wait: assert property (i_psel && !i_penable |=> ##1 o_pready)
    else $error("ready not two cycles after setup");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (o_pslverr |-> o_pready &&
      !(i_paddr inside {12'h000, 12'h004, 12'h008}))
    else $error("error on a mapped address");
  a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0000_0000)
    else $error("read data outside answer cycle");
endmodule

bind wwdt_top wwdt_chk chk_u (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_psel(i_psel),
  .i_penable(i_penable), .i_paddr(i_paddr),
  .i_watchdog_clear_instr(i_watchdog_clear_instr),
  .i_clock_switch_done(i_clock_switch_done), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_watchdog_reset(o_watchdog_reset),
  .o_wake(o_wake), .o_low_power_rc_osc_on(o_low_power_rc_osc_on)
);

// ==== verilog/wwdt_counter.sv ====
// Prescaler and postscaler chain of the windowed watchdog as one counter.
// Assumes the control side supplies a tick of the oscillator rate.
`include "wwdt_params.svh"

module wwdt_counter (
  input  wire logic i_clock,
  input  wire logic i_nrst,
  wwdt_cnt_if.core  cnt
);

  // Last count value of a period of two to the power shift ticks.
  function automatic wwdt_pkg::wwdt_count_t last_count(
    input logic [4:0] sh
  );
    logic [22:0] full;
    full = (23'h00_0001 << sh) - 23'h00_0001;
    return full[21:0];
  endfunction

  wwdt_pkg::wwdt_count_t count_reg;   // Chained prescaler and postscaler.
  wwdt_pkg::wwdt_count_t count_next;  // Next chain value.
  logic                  expire_reg;  // Registered time-out pulse.
  wire                   at_end;      // Chain holds its last value.
  wire                   step;        // Chain advances this cycle.
  wire [22:0]            win_start;   // First count of the final quarter.

  assign at_end    = (count_reg == last_count(cnt.shift));
  assign step      = cnt.run && cnt.tick && !cnt.clear;
  assign win_start = 23'h00_0003 << (cnt.shift - 5'h02);

  // A clear beats a tick, so a restart never counts a stale tick.
  always_comb begin
    count_next = count_reg;
    if (cnt.clear || !cnt.run) begin
      count_next = '0;
    end else if (step) begin
      count_next = at_end ? '0 : count_reg + 22'h00_0001;
    end
  end

  // The chain wraps to zero in the cycle it signals expiry.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      count_reg  <= '0;
      expire_reg <= 1'b0;
    end else begin
      count_reg  <= count_next;
      expire_reg <= step && at_end;
    end
  end

  assign cnt.count       = count_reg;
  assign cnt.expire      = expire_reg;
  assign cnt.window_open = ({1'b0, count_reg} >= win_start);

endmodule

// ==== verilog/wwdt_top.sv ====
// Windowed watchdog timer with its APB register slave.
// Assumes a 100 MHz clock, one-cycle event pulses from the CPU and
// clock logic, and a system reset manager that acts on o_watchdog_reset.
//
// Summary of operation
// - Clock from low-power oscillator; enabling starts it.
// - Prescaler divides by 32 or 128.
// - Base period about 1 ms or 4 ms.
// - Postscaler picks one of sixteen ratios.
// - Device reset and clock switch restart counting.
// - Power-save entry, exit and clear restart counting.
// - Always-on setting keeps counting in Sleep, Idle.
// - Time-out in Sleep or Idle wakes, no reset.
// - Time-out sets sticky flag, never self-cleared.
// - Windowed clear works only in last quarter.
// - Early windowed clear causes watchdog reset.
// - Window-disable bit zero selects windowed mode.
// - Enable field 11 means permanently on.
// - Enable field 10 follows software-enable bit.
// - Device reset clears software-enable bit.
// - Field 01 runs in Run, Idle; bit ignored.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`include "wwdt_params.svh"

module wwdt_top (
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  // APB slave.
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // CPU and clock-system events, one cycle each.
  input  wire logic        i_watchdog_clear_instr,
  input  wire logic        i_power_save_sleep,
  input  wire logic        i_power_save_idle,
  input  wire logic        i_wake_other,
  input  wire logic        i_clock_switch_done,
  // Effects on the rest of the device.
  output logic             o_watchdog_reset,
  output logic             o_wake,
  output logic             o_low_power_rc_osc_on
);

  // Register state.
  logic [31:0]          config_reg;         // Watchdog configuration word.
  logic                 soft_en_reg;        // Software watchdog enable.
  logic                 timeout_flag_reg;   // Sticky time-out flag.
  logic                 sleep_flag_reg;     // Woke from Sleep.
  logic                 idle_flag_reg;      // Woke from Idle.
  wwdt_pkg::wwdt_mode_e mode_reg;           // Tracked power state.
  wwdt_pkg::wwdt_mode_e mode_next;          // Next power state.
  logic [11:0]          div_reg;            // Oscillator period divider.
  logic                 osc_on_reg;         // Oscillator request.
  logic                 wd_reset_reg;       // Reset request pulse.
  logic                 wake_reg;           // Wake request pulse.
  logic [31:0]          prdata_reg;         // Read data.
  logic                 pready_reg;         // Access completes.
  logic                 pslverr_reg;        // Unmapped access.

  wwdt_cnt_if cnt ();

  // Decoded configuration.
  wire [3:0] postscale_select;
  wire       prescale_select;
  wire       window_disable;
  wire [1:0] watchdog_enable_field;

  assign postscale_select      =
    config_reg[`WWDT_CFG_PS_HI:`WWDT_CFG_PS_LO];
  assign prescale_select       = config_reg[`WWDT_CFG_PRESCALE];
  assign window_disable        = config_reg[`WWDT_CFG_WIN_DIS];
  assign watchdog_enable_field =
    config_reg[`WWDT_CFG_EN_HI:`WWDT_CFG_EN_LO];

  // Enable decoding per setting of the enable field.
  wire in_run      = (mode_reg == wwdt_pkg::WWDT_RUN);
  wire in_sleep    = (mode_reg == wwdt_pkg::WWDT_SLEEP);
  wire in_idle     = (mode_reg == wwdt_pkg::WWDT_IDLE);
  wire en_always   = (watchdog_enable_field == 2'h3);
  wire en_soft     = (watchdog_enable_field == 2'h2) && soft_en_reg;
  wire en_awake    = (watchdog_enable_field == 2'h1) && !in_sleep;
  // Field 00 matches none of the terms, so the chain stays at zero.
  wire running     = en_always || en_soft || en_awake;
  wire windowed    = !window_disable;

  // Prescaler width: 5 bits for divide by 32, 7 for divide by 128.
  wire [4:0] pre_bits = prescale_select ? `WWDT_PRE_LONG
                                        : `WWDT_PRE_SHORT;
  // Postscaler 1:1 to 1:32768 adds zero to fifteen bits.
  wire [4:0] total_shift = pre_bits + {1'b0, postscale_select};

  // Oscillator tick: the divider models one period of the nominal
  // oscillator, so a base period is 32 or 128 of these ticks.
  wire [11:0] div_last = 12'(`WWDT_OSC_DIV - 1);
  wire        osc_tick = osc_on_reg && (div_reg == div_last);

  // Clear-instruction handling in and out of the window.
  wire clr_early   = i_watchdog_clear_instr && running && windowed &&
                     !cnt.window_open;
  wire clr_accept  = i_watchdog_clear_instr && !clr_early;

  // Time-out outcome depends on the power state at expiry.
  wire to_asleep   = cnt.expire && !in_run;
  wire to_awake    = cnt.expire && in_run;
  wire wake_exit   = to_asleep || (i_wake_other && !in_run);

  // Restart sources of the counter chain.
  assign cnt.clear = i_clock_switch_done || i_power_save_sleep ||
                     i_power_save_idle || wake_exit ||
                     clr_accept || clr_early;
  assign cnt.run   = running;
  assign cnt.tick  = osc_tick;
  assign cnt.shift = total_shift;

  wwdt_counter u_counter (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .cnt     (cnt)
  );

  // APB decode. The slave inserts one wait state per access.
  wire apb_acc   = i_psel && i_penable && pready_reg;
  wire apb_wr    = apb_acc && i_pwrite;
  wire sel_rc    = (i_paddr == `WWDT_ADDR_RESET_CTRL);
  wire sel_cfg   = (i_paddr == `WWDT_ADDR_CONFIG);
  wire sel_st    = (i_paddr == `WWDT_ADDR_STATUS);
  wire mapped    = sel_rc || sel_cfg || sel_st;
  wire wr_rc     = apb_wr && sel_rc;
  wire wr_cfg    = apb_wr && sel_cfg;

  // Read views.
  wire [31:0] rc_view = {26'h000_0000, soft_en_reg, timeout_flag_reg,
                         sleep_flag_reg, idle_flag_reg, 2'h0};
  wire [31:0] st_view = {4'h0, in_idle, in_sleep, running,
                         cnt.window_open, 2'h0, cnt.count};
  wire [31:0] rd_mux  = sel_rc  ? rc_view :
                        sel_cfg ? config_reg :
                        sel_st  ? st_view : 32'h0000_0000;

  // Software writes a zero to clear a flag; writing one is ignored.
  wire clr_to    = wr_rc && !i_pwdata[`WWDT_RC_TIMEOUT];
  wire clr_sleep = wr_rc && !i_pwdata[`WWDT_RC_SLEEP];
  wire clr_idle  = wr_rc && !i_pwdata[`WWDT_RC_IDLE];
  wire set_to    = cnt.expire || clr_early;

  // Power-state tracking.
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      wwdt_pkg::WWDT_RUN: begin
        if (i_power_save_sleep) begin
          mode_next = wwdt_pkg::WWDT_SLEEP;
        end else if (i_power_save_idle) begin
          mode_next = wwdt_pkg::WWDT_IDLE;
        end
      end
      wwdt_pkg::WWDT_SLEEP,
      wwdt_pkg::WWDT_IDLE: begin
        // Execution resumes after the power-save point.
        if (wake_exit) begin
          mode_next = wwdt_pkg::WWDT_RUN;
        end
      end
      default: begin
        mode_next = wwdt_pkg::WWDT_RUN;
      end
    endcase
  end

  // Mode register.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      mode_reg <= wwdt_pkg::WWDT_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Oscillator request and its period divider. Holding the divider at
  // zero while off mimics an oscillator that restarts from rest.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      osc_on_reg <= 1'b0;
      div_reg    <= 12'h000;
    end else begin
      osc_on_reg <= running;
      if (!osc_on_reg || osc_tick) begin
        div_reg <= 12'h000;
      end else begin
        div_reg <= div_reg + 12'h001;
      end
    end
  end

  // Configuration word. It is writable so software can stand in for
  // the fixed configuration fuses; a real part would lock it.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      config_reg <= `WWDT_CFG_RESET;
    end else if (wr_cfg) begin
      config_reg <= i_pwdata;
    end
  end

  // Software enable takes writes only under enable field 10.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      soft_en_reg <= 1'b0;
    end else if (wr_rc && watchdog_enable_field == 2'h2) begin
      soft_en_reg <= i_pwdata[`WWDT_RC_SOFT_EN];
    end
  end

  // Sticky flags: a hardware set in the same cycle as a clear wins,
  // so no event is lost to a racing software write.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      timeout_flag_reg <= 1'b0;
      sleep_flag_reg   <= 1'b0;
      idle_flag_reg    <= 1'b0;
    end else begin
      if (set_to) begin
        timeout_flag_reg <= 1'b1;
      end else if (clr_to) begin
        timeout_flag_reg <= 1'b0;
      end
      if (i_power_save_sleep && in_run) begin
        sleep_flag_reg <= 1'b1;
      end else if (clr_sleep) begin
        sleep_flag_reg <= 1'b0;
      end
      if (i_power_save_idle && in_run && !i_power_save_sleep) begin
        idle_flag_reg <= 1'b1;
      end else if (clr_idle) begin
        idle_flag_reg <= 1'b0;
      end
    end
  end

  // Event outputs: reset for a run-mode expiry or an early clear,
  // wake for an expiry during Sleep or Idle.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      wd_reset_reg  <= 1'b0;
      wake_reg      <= 1'b0;
    end else begin
      wd_reset_reg  <= to_awake || clr_early;
      wake_reg      <= to_asleep;
    end
  end

  // APB handshake: ready rises in the second access cycle and drops
  // after the completing edge, giving exactly one wait state.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= i_psel && i_penable && !pready_reg;
      if (i_psel && i_penable && !pready_reg) begin
        prdata_reg  <= i_pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_reg <= !mapped;
      end else begin
        prdata_reg  <= 32'h0000_0000;
        pslverr_reg <= 1'b0;
      end
    end
  end

  // Every output is a flip-flop.
  assign o_prdata              = prdata_reg;
  assign o_pready              = pready_reg;
  assign o_pslverr             = pslverr_reg;
  assign o_watchdog_reset      = wd_reset_reg;
  assign o_wake                = wake_reg;
  assign o_low_power_rc_osc_on = osc_on_reg;

endmodule
